// [src/suad_consts.svh]
// Constants for the store unit address and data path
`ifndef SUAD_CONSTS_SVH
`define SUAD_CONSTS_SVH

`define SUAD_XLEN           32
`define SUAD_SHORT_DISP_W   10
`define SUAD_LONG_DISP_W    16
`define SUAD_TINY_DISP_W    4
`define SUAD_BPOS_W         3
`define SUAD_BYTE_MSB       7
`define SUAD_HALF_MSB       15
`define SUAD_UPPER_LSB      16
`define SUAD_REG_IDX_W      4
`define SUAD_IMPLICIT_BASE  4'hf
`define SUAD_INC_WORD       32'h0000_0004
`define SUAD_INC_BYTE       32'h0000_0001
`define SUAD_INC_HALF       32'h0000_0001
`define SUAD_PAIR_STEP      32'h0000_0004
`define SUAD_BIT_ONE        8'h01
`define SUAD_WORD_ZERO      32'h0000_0000

`endif

// [src/suad_pkg.sv]
// Types shared by the store unit address and data path
`include "suad_consts.svh"
package suad_pkg;

   typedef enum logic [2:0] {
      SUAD_OP_POINTER_WORD = 3'h0, // store_pointer_word
      SUAD_OP_DATA_WORD    = 3'h1, // store_data_word
      SUAD_OP_LOW_BYTE     = 3'h2, // store_low_byte
      SUAD_OP_LOW_HALF     = 3'h3, // store_low_half
      SUAD_OP_UPPER_FRAC   = 3'h4, // store_upper_half_fraction
      SUAD_OP_DATA_PAIR    = 3'h5, // store_data_pair
      SUAD_OP_POINTER_PAIR = 3'h6, // store_pointer_pair
      SUAD_OP_SINGLE_BIT   = 3'h7  // store_single_bit
   } suad_op_e;

   typedef enum logic [3:0] {
      SUAD_MODE_DIRECT_ADDR   = 4'h0, // direct_address_format, address formed outside
      SUAD_MODE_BASE_DISP     = 4'h1, // base_displacement_format
      SUAD_MODE_PRE_INC       = 4'h2,
      SUAD_MODE_POST_INC      = 4'h3,
      SUAD_MODE_CIRCULAR      = 4'h4, // address formed outside
      SUAD_MODE_BIT_REVERSE   = 4'h5, // address formed outside
      SUAD_MODE_BASE_WIDE     = 4'h6, // base_wide_displacement_format
      SUAD_MODE_SHORT_IND     = 4'h7, // short_indirect_format
      SUAD_MODE_SHORT_IMPL_B  = 4'h8, // short_implicit_base_format
      SUAD_MODE_SHORT_IMPL_R  = 4'h9, // short_implicit_reg_format
      SUAD_MODE_SHORT_POST    = 4'ha, // short_indirect_format, post-increment
      SUAD_MODE_DIRECT_BIT    = 4'hb  // direct_bit_format
   } suad_mode_e;

   typedef enum logic [1:0] {
      SUAD_SIZE_BYTE = 2'h0,
      SUAD_SIZE_HALF = 2'h1,
      SUAD_SIZE_WORD = 2'h2
   } suad_size_e;

   // Gray coded along IDLE -> ISSUE -> SECOND, and IDLE -> RD_REQ -> RD_WAIT -> ISSUE
   typedef enum logic [2:0] {
      SUAD_ST_IDLE    = 3'h0,
      SUAD_ST_ISSUE   = 3'h1,
      SUAD_ST_SECOND  = 3'h3,
      SUAD_ST_RD_REQ  = 3'h4,
      SUAD_ST_RD_WAIT = 3'h5
   } suad_state_e;

   typedef struct packed {
      suad_op_e                          op;
      suad_mode_e                        mode;
      logic [`SUAD_REG_IDX_W-1:0]        base_idx;
      logic [`SUAD_XLEN-1:0]             base_val;
      logic [`SUAD_XLEN-1:0]             implicit_base_val;
      logic [`SUAD_XLEN-1:0]             src_lo;
      logic [`SUAD_XLEN-1:0]             src_hi;
      logic [`SUAD_LONG_DISP_W-1:0]      disp;
      logic [`SUAD_BPOS_W-1:0]           bit_pos;
      logic                              bit_val;
      logic [`SUAD_XLEN-1:0]             ext_addr;
   } suad_req_s;

   typedef struct packed {
      logic                              we;
      suad_size_e                        size;
      logic [`SUAD_XLEN-1:0]             addr;
      logic [`SUAD_XLEN-1:0]             data;
   } suad_mem_s;

   typedef struct packed {
      logic [`SUAD_REG_IDX_W-1:0]        idx;
      logic [`SUAD_XLEN-1:0]             data;
   } suad_wb_s;

endpackage : suad_pkg

// [src/suad_ext.sv]
// Displacement field extender to a full address word
`timescale 1ns/10ps
`default_nettype none
`include "suad_consts.svh"
module suad_ext #(
   parameter int unsigned IN_W   = 10,
   parameter bit          SIGNED = 1'b1
) (
   input  wire logic [IN_W-1:0]       field_in,
   output logic      [`SUAD_XLEN-1:0] value_out
);

   logic fill;

   assign fill      = SIGNED & field_in[IN_W-1];
   assign value_out = {{(`SUAD_XLEN-IN_W){fill}}, field_in};

endmodule : suad_ext
`default_nettype wire

// [src/suad_store_unit.sv]
// Store unit: effective address, store data placement and base update
`timescale 1ns/10ps
`default_nettype none
`include "suad_consts.svh"
module suad_store_unit
   import suad_pkg::*;
(
   input  wire logic      mclk_in,
   input  wire logic      sys_rst_in,
   input  wire logic      req_valid_in,
   input  wire suad_req_s req_in,
   output logic           req_ready_out,
   output logic           req_error_out,
   output logic           mem_req_out,
   output suad_mem_s      mem_cmd_out,
   input  wire logic      mem_ready_in,
   input  wire logic      mem_rvalid_in,
   input  wire logic [7:0] mem_rdata_in,
   output logic           wb_valid_out,
   output suad_wb_s       wb_out,
   output logic           done_out
);

   ////////////////////////////////////////////////////////////////////////////
   // Displacement extension

   logic [`SUAD_XLEN-1:0] short_sx;
   logic [`SUAD_XLEN-1:0] long_sx;
   logic [`SUAD_XLEN-1:0] tiny_zx;

   suad_ext #(.IN_W(`SUAD_SHORT_DISP_W), .SIGNED(1'b1)) u_short_ext (
      .field_in  (req_in.disp[`SUAD_SHORT_DISP_W-1:0]),
      .value_out (short_sx)
   );

   suad_ext #(.IN_W(`SUAD_LONG_DISP_W), .SIGNED(1'b1)) u_long_ext (
      .field_in  (req_in.disp),
      .value_out (long_sx)
   );

   suad_ext #(.IN_W(`SUAD_TINY_DISP_W), .SIGNED(1'b0)) u_tiny_ext (
      .field_in  (req_in.disp[`SUAD_TINY_DISP_W-1:0]),
      .value_out (tiny_zx)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Request decode

   suad_state_e           state_reg;
   logic                  accept;
   logic                  legal;
   logic                  is_pair;
   logic                  is_bit;
   logic                  long_mode;
   logic                  short_mode;
   logic [`SUAD_XLEN-1:0] ea;
   logic [`SUAD_XLEN-1:0] short_inc;
   logic [`SUAD_XLEN-1:0] first_data;
   suad_size_e            first_size;
   logic                  wb_pre;
   logic                  wb_post;
   logic [`SUAD_XLEN-1:0] wb_value;

   assign accept  = (state_reg == SUAD_ST_IDLE) & req_valid_in;
   assign is_pair = (req_in.op == SUAD_OP_DATA_PAIR) | (req_in.op == SUAD_OP_POINTER_PAIR);
   assign is_bit  = (req_in.op == SUAD_OP_SINGLE_BIT);

   always_comb begin
      long_mode  = 1'b0;
      short_mode = 1'b0;
      case (req_in.mode)
         SUAD_MODE_DIRECT_ADDR,
         SUAD_MODE_BASE_DISP,
         SUAD_MODE_PRE_INC,
         SUAD_MODE_POST_INC,
         SUAD_MODE_CIRCULAR,
         SUAD_MODE_BIT_REVERSE: long_mode = 1'b1;
         SUAD_MODE_SHORT_IND,
         SUAD_MODE_SHORT_IMPL_B,
         SUAD_MODE_SHORT_IMPL_R,
         SUAD_MODE_SHORT_POST: short_mode = 1'b1;
         default: begin
            long_mode  = 1'b0;
            short_mode = 1'b0;
         end
      endcase
   end

   // Combinations the instruction set cannot encode are refused, nothing is written
   always_comb begin
      if (is_bit) begin
         legal = (req_in.mode == SUAD_MODE_DIRECT_BIT);
      end else if (req_in.mode == SUAD_MODE_BASE_WIDE) begin
         legal = (req_in.op == SUAD_OP_DATA_WORD);
      end else if (short_mode) begin
         legal = (req_in.op == SUAD_OP_POINTER_WORD) | (req_in.op == SUAD_OP_DATA_WORD) |
                 (req_in.op == SUAD_OP_LOW_BYTE) | (req_in.op == SUAD_OP_LOW_HALF);
      end else begin
         legal = long_mode;
      end
   end

   always_comb begin
      case (req_in.mode)
         SUAD_MODE_BASE_DISP:    ea = req_in.base_val + short_sx;
         SUAD_MODE_PRE_INC:      ea = req_in.base_val + short_sx;
         SUAD_MODE_POST_INC:     ea = req_in.base_val;
         SUAD_MODE_BASE_WIDE:    ea = req_in.base_val + long_sx;
         SUAD_MODE_SHORT_IND:    ea = req_in.base_val;
         SUAD_MODE_SHORT_POST:   ea = req_in.base_val;
         SUAD_MODE_SHORT_IMPL_B: ea = req_in.implicit_base_val + tiny_zx;
         SUAD_MODE_SHORT_IMPL_R: ea = req_in.base_val + tiny_zx;
         default:                ea = req_in.ext_addr;
      endcase
   end

   always_comb begin
      case (req_in.op)
         SUAD_OP_LOW_BYTE: short_inc = `SUAD_INC_BYTE;
         // Halfword step kept at one as documented; a two-byte step looks more natural
         SUAD_OP_LOW_HALF: short_inc = `SUAD_INC_HALF;
         default:          short_inc = `SUAD_INC_WORD;
      endcase
   end

   always_comb begin
      first_data = req_in.src_lo;
      first_size = SUAD_SIZE_WORD;
      case (req_in.op)
         SUAD_OP_LOW_BYTE: begin
            first_data = {24'h00_0000, req_in.src_lo[`SUAD_BYTE_MSB:0]};
            first_size = SUAD_SIZE_BYTE;
         end
         SUAD_OP_LOW_HALF: begin
            first_data = {16'h0000, req_in.src_lo[`SUAD_HALF_MSB:0]};
            first_size = SUAD_SIZE_HALF;
         end
         SUAD_OP_UPPER_FRAC: begin
            first_data = {16'h0000, req_in.src_lo[`SUAD_XLEN-1:`SUAD_UPPER_LSB]};
            first_size = SUAD_SIZE_HALF;
         end
         SUAD_OP_SINGLE_BIT: begin
            first_data = `SUAD_WORD_ZERO;
            first_size = SUAD_SIZE_BYTE;
         end
         default: begin
            first_data = req_in.src_lo;
            first_size = SUAD_SIZE_WORD;
         end
      endcase
   end

   assign wb_pre   = (req_in.mode == SUAD_MODE_PRE_INC);
   assign wb_post  = (req_in.mode == SUAD_MODE_POST_INC) | (req_in.mode == SUAD_MODE_SHORT_POST);
   assign wb_value = (req_in.mode == SUAD_MODE_SHORT_POST) ?
                     (req_in.base_val + short_inc) : (req_in.base_val + short_sx);

   ////////////////////////////////////////////////////////////////////////////
   // Sequencer

   logic                     pair_reg;
   logic [`SUAD_XLEN-1:0]    hi_data_reg;
   logic [`SUAD_BPOS_W-1:0]  bpos_reg;
   logic                     bval_reg;
   logic                     post_pending_reg;
   logic                     final_accept;

   assign final_accept = mem_ready_in &
                         (((state_reg == SUAD_ST_ISSUE) & ~pair_reg) | (state_reg == SUAD_ST_SECOND));

   always_ff @(posedge mclk_in) begin
      if (sys_rst_in) begin
         state_reg <= SUAD_ST_IDLE;
      end else begin
         case (state_reg)
            SUAD_ST_IDLE: begin
               if (accept & legal) begin
                  state_reg <= is_bit ? SUAD_ST_RD_REQ : SUAD_ST_ISSUE;
               end
            end
            SUAD_ST_ISSUE: begin
               if (mem_ready_in) begin
                  state_reg <= pair_reg ? SUAD_ST_SECOND : SUAD_ST_IDLE;
               end
            end
            SUAD_ST_SECOND: begin
               if (mem_ready_in) begin
                  state_reg <= SUAD_ST_IDLE;
               end
            end
            SUAD_ST_RD_REQ: begin
               if (mem_ready_in) begin
                  state_reg <= SUAD_ST_RD_WAIT;
               end
            end
            SUAD_ST_RD_WAIT: begin
               if (mem_rvalid_in) begin
                  state_reg <= SUAD_ST_ISSUE;
               end
            end
            default: state_reg <= SUAD_ST_IDLE;
         endcase
      end
   end

   // Operands held for the later beats of a request
   always_ff @(posedge mclk_in) begin
      if (sys_rst_in) begin
         pair_reg    <= 1'b0;
         hi_data_reg <= `SUAD_WORD_ZERO;
         bpos_reg    <= '0;
         bval_reg    <= 1'b0;
      end else if (accept & legal) begin
         pair_reg    <= is_pair;
         hi_data_reg <= req_in.src_hi;
         bpos_reg    <= req_in.bit_pos;
         bval_reg    <= req_in.bit_val;
      end
   end

   always_ff @(posedge mclk_in) begin
      if (sys_rst_in) begin
         req_ready_out <= 1'b1;
      end else if (accept) begin
         req_ready_out <= ~legal;
      end else if (final_accept) begin
         req_ready_out <= 1'b1;
      end
   end

   always_ff @(posedge mclk_in) begin
      if (sys_rst_in) begin
         req_error_out <= 1'b0;
      end else begin
         req_error_out <= accept & ~legal;
      end
   end

   always_ff @(posedge mclk_in) begin
      if (sys_rst_in) begin
         done_out <= 1'b0;
      end else begin
         done_out <= final_accept;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Memory request

   logic [7:0] merged_byte;

   // Read-modify-write keeps the other seven bits; no bit-masked write needed downstream
   assign merged_byte = (mem_rdata_in & ~(`SUAD_BIT_ONE << bpos_reg)) |
                        ({7'h00, bval_reg} << bpos_reg);

   always_ff @(posedge mclk_in) begin
      if (sys_rst_in) begin
         mem_req_out <= 1'b0;
      end else if (accept & legal) begin
         mem_req_out <= 1'b1;
      end else if ((state_reg == SUAD_ST_RD_WAIT) & mem_rvalid_in) begin
         mem_req_out <= 1'b1;
      end else if (mem_ready_in & (state_reg == SUAD_ST_RD_REQ)) begin
         mem_req_out <= 1'b0;
      end else if (final_accept) begin
         mem_req_out <= 1'b0;
      end
   end

   always_ff @(posedge mclk_in) begin
      if (sys_rst_in) begin
         mem_cmd_out <= '0;
      end else if (accept & legal) begin
         mem_cmd_out.we   <= ~is_bit;
         mem_cmd_out.size <= first_size;
         mem_cmd_out.addr <= ea;
         mem_cmd_out.data <= first_data;
      end else if ((state_reg == SUAD_ST_RD_WAIT) & mem_rvalid_in) begin
         mem_cmd_out.we   <= 1'b1;
         mem_cmd_out.data <= {24'h00_0000, merged_byte};
      end else if ((state_reg == SUAD_ST_ISSUE) & mem_ready_in & pair_reg) begin
         mem_cmd_out.addr <= mem_cmd_out.addr + `SUAD_PAIR_STEP;
         mem_cmd_out.data <= hi_data_reg;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Base register update

   always_ff @(posedge mclk_in) begin
      if (sys_rst_in) begin
         post_pending_reg <= 1'b0;
      end else if (accept & legal) begin
         post_pending_reg <= wb_post;
      end else if (final_accept) begin
         post_pending_reg <= 1'b0;
      end
   end

   always_ff @(posedge mclk_in) begin
      if (sys_rst_in) begin
         wb_valid_out <= 1'b0;
      end else begin
         wb_valid_out <= (accept & legal & wb_pre) |
                         (final_accept & post_pending_reg);
      end
   end

   always_ff @(posedge mclk_in) begin
      if (sys_rst_in) begin
         wb_out <= '0;
      end else if (accept & legal) begin
         wb_out.idx  <= req_in.base_idx;
         wb_out.data <= wb_value;
      end
   end

endmodule : suad_store_unit
`default_nettype wire

// [tb/suad_mem_model.sv]
// Memory partner answering the store unit's requests
`timescale 1ns/10ps
`default_nettype none
module suad_mem_model
   import suad_pkg::*;
(
   input  wire logic       mclk_in,
   input  wire logic       sys_rst_in,
   input  wire logic       slow_in,
   input  wire logic       clr_in,
   input  wire logic       req_in,
   input  wire suad_mem_s  cmd_in,
   input  wire logic [7:0] rd_byte_in,
   output logic            ready_out,
   output logic            rvalid_out,
   output logic [7:0]      rdata_out
);
   logic [31:0] wa [4];
   logic [31:0] wd [4];
   logic [1:0]  ws [4];
   int          nw;
   int          wait_n;
   int          rd_n;
   logic        rd_pend;
   ////////////////////////////////////////
   // Slow mode makes the core hold its request two extra cycles
   assign ready_out = req_in && (!slow_in || wait_n == 2);
   always @(posedge mclk_in) begin
      rvalid_out <= 1'b0;
      // Stale read data keeps changing so it never passes as valid
      rdata_out <= ~rdata_out;
      if (sys_rst_in) begin
         wait_n <= 0;
         rd_pend <= 1'b0;
         rdata_out <= 8'h00;
         nw = 0;
      end else begin
         // Write log restarts with each scenario
         if (clr_in) nw = 0;
         wait_n <= (req_in && !ready_out) ? wait_n + 1 : 0;
         if (req_in && ready_out && !cmd_in.we) begin
            rd_pend <= 1'b1;
            rd_n <= slow_in ? 3 : 0;
         end else if (rd_pend && rd_n == 0) begin
            rd_pend <= 1'b0;
            rvalid_out <= 1'b1;
            rdata_out <= rd_byte_in;
         end else if (rd_pend) begin
            rd_n <= rd_n - 1;
         end
         if (req_in && ready_out && cmd_in.we && nw < 4) begin
            wa[nw] = cmd_in.addr;
            wd[nw] = cmd_in.data;
            ws[nw] = cmd_in.size;
            nw = nw + 1;
         end
      end
   end
endmodule : suad_mem_model
`default_nettype wire

// [tb/suad_store_unit_asserts.sv]
// Port-level checker for the store unit
`timescale 1ns/10ps
`default_nettype none
module suad_store_unit_asserts
   import suad_pkg::*;
(
   input wire logic       mclk_in,
   input wire logic       sys_rst_in,
   input wire logic       req_valid_in,
   input wire suad_req_s  req_in,
   input wire logic       req_ready_out,
   input wire logic       req_error_out,
   input wire logic       mem_req_out,
   input wire suad_mem_s  mem_cmd_out,
   input wire logic       mem_ready_in,
   input wire logic       mem_rvalid_in,
   input wire logic [7:0] mem_rdata_in,
   input wire logic       wb_valid_out,
   input wire suad_wb_s   wb_out,
   input wire logic       done_out
);
   default clocking cb @(posedge mclk_in);
   endclocking
   default disable iff (sys_rst_in);
   ////////////////////////////////////////
   a_cmd_hold: assert property (mem_req_out && !mem_ready_in |=>
      mem_req_out && $stable(mem_cmd_out)) else $error("memory command changed while waiting");
   a_busy_ready: assert property (mem_req_out |-> !req_ready_out)
      else $error("ready high during a store");
   a_accept_answer: assert property (req_valid_in && req_ready_out |=>
      mem_req_out || req_error_out) else $error("accepted request got no answer");
   a_byte_clean: assert property (mem_req_out && mem_cmd_out.size == SUAD_SIZE_BYTE
      |-> mem_cmd_out.data[31:8] == 24'h000000) else $error("byte store carries upper bits");
   a_half_clean: assert property (mem_req_out && mem_cmd_out.size == SUAD_SIZE_HALF
      |-> mem_cmd_out.data[31:16] == 16'h0000) else $error("half store carries upper bits");
   a_merge_write: assert property (mem_rvalid_in |=> mem_req_out && mem_cmd_out.we &&
      mem_cmd_out.size == SUAD_SIZE_BYTE) else $error("merged byte write missing");
   a_err_quiet: assert property (req_error_out |->
      !mem_req_out && req_ready_out && !done_out) else $error("refused request issued");
   a_done_pulse: assert property (done_out |-> req_ready_out ##1 !done_out)
      else $error("done not a single pulse");
   a_done_after: assert property (done_out |->
      $past(mem_req_out) && $past(mem_ready_in)) else $error("done without memory accept");
   a_wb_pulse: assert property (wb_valid_out |=> !wb_valid_out)
      else $error("writeback not a single pulse");
endmodule : suad_store_unit_asserts
`default_nettype wire

// [tb/suad_store_unit_tb.sv]
// Self-checking testbench for the store unit
`timescale 1ns/10ps
`default_nettype none
bind suad_store_unit suad_store_unit_asserts chk_i (.mclk_in(mclk_in), .sys_rst_in(sys_rst_in),
   .req_valid_in(req_valid_in), .req_in(req_in), .req_ready_out(req_ready_out),
   .req_error_out(req_error_out), .mem_req_out(mem_req_out), .mem_cmd_out(mem_cmd_out),
   .mem_ready_in(mem_ready_in), .mem_rvalid_in(mem_rvalid_in), .mem_rdata_in(mem_rdata_in),
   .wb_valid_out(wb_valid_out), .wb_out(wb_out), .done_out(done_out));
module suad_store_unit_tb
   import suad_pkg::*;
;
   localparam logic [31:0] LO = 32'h1122_3344;
   localparam logic [31:0] HI = 32'h5566_7788;
   logic        mclk_in = 1'b0;
   logic        sys_rst_in = 1'b1;
   logic        req_valid = 1'b0;
   logic        slow = 1'b0;
   logic        clr = 1'b0;
   logic [7:0]  rd_byte = 8'h00;
   logic [2:0]  bpos = 3'h0;
   logic        bval = 1'b0;
   suad_req_s   req = '0;
   logic        ready, err, mreq, mrdy, rvalid, wbv, done;
   logic [7:0]  rdata;
   suad_mem_s   cmd;
   suad_wb_s    wb;
   int          failures = 0;
   int          num_checks = 0;
   int          wb_n, err_n;
   logic [31:0] wb_d;
   suad_store_unit uut (.mclk_in(mclk_in), .sys_rst_in(sys_rst_in), .req_valid_in(req_valid),
      .req_in(req), .req_ready_out(ready), .req_error_out(err), .mem_req_out(mreq),
      .mem_cmd_out(cmd), .mem_ready_in(mrdy), .mem_rvalid_in(rvalid), .mem_rdata_in(rdata),
      .wb_valid_out(wbv), .wb_out(wb), .done_out(done));
   suad_mem_model mem (.mclk_in(mclk_in), .sys_rst_in(sys_rst_in), .slow_in(slow), .clr_in(clr),
      .req_in(mreq), .cmd_in(cmd), .rd_byte_in(rd_byte), .ready_out(mrdy),
      .rvalid_out(rvalid), .rdata_out(rdata));
   always #10 mclk_in = ~mclk_in;
   ////////////////////////////////////////
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         failures++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic finish_test();
      $display("checks %0d mismatches %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : finish_test
   // One request, then wait for done or refusal under a bound
   task automatic st(input suad_op_e op, input suad_mode_e md, input logic [31:0] base,
      input logic [15:0] disp, input logic [31:0] ea, input logic [31:0] dat,
      input suad_size_e sz, input int nwe, input int wbn, input logic [31:0] wbe);
      suad_req_s r;
      int n;
      r = '0;
      r.op = op;
      r.mode = md;
      r.base_idx = 4'h6;
      r.base_val = base;
      r.implicit_base_val = 32'h0000_5000;
      r.src_lo = LO;
      r.src_hi = HI;
      r.disp = disp;
      r.bit_pos = bpos;
      r.bit_val = bval;
      r.ext_addr = base;
      clr <= 1'b1;
      wb_n = 0;
      err_n = 0;
      @(posedge mclk_in);
      clr <= 1'b0;
      req_valid <= 1'b1;
      req <= r;
      @(posedge mclk_in);
      req_valid <= 1'b0;
      for (n = 0; n < 50; n++) begin
         #1;
         if (wbv === 1'b1) begin
            wb_n++;
            wb_d = wb.data;
            chk({28'h0, wb.idx}, 32'h6);
         end
         if (err === 1'b1) err_n++;
         if (done === 1'b1 || err === 1'b1) break;
         @(posedge mclk_in);
      end
      chk({31'h0, n < 50}, 32'h1);
      chk(32'(mem.nw), 32'(nwe));
      chk(32'(err_n), {31'h0, nwe == 0});
      chk(32'(wb_n), 32'(wbn));
      if (wbn > 0) chk(wb_d, wbe);
      if (nwe > 0) begin
         chk(mem.wa[0], ea);
         chk(mem.wd[0], dat);
         chk({30'h0, mem.ws[0]}, {30'h0, sz});
      end
   endtask : st
   task automatic t_long();
      st(SUAD_OP_POINTER_WORD, SUAD_MODE_BASE_DISP, 32'h1000_0000, 16'h53f0, 32'h0fff_fff0,
         LO, SUAD_SIZE_WORD, 1, 0, 0);
      st(SUAD_OP_DATA_WORD, SUAD_MODE_BASE_WIDE, 32'h1000_0000, 16'h8000, 32'h0fff_8000,
         LO, SUAD_SIZE_WORD, 1, 0, 0);
      st(SUAD_OP_LOW_BYTE, SUAD_MODE_PRE_INC, 32'h2000, 16'h0410, 32'h2010, 32'h44,
         SUAD_SIZE_BYTE, 1, 1, 32'h2010);
      st(SUAD_OP_LOW_HALF, SUAD_MODE_POST_INC, 32'h3000, 16'h03fe, 32'h3000, 32'h3344,
         SUAD_SIZE_HALF, 1, 1, 32'h2ffe);
      st(SUAD_OP_UPPER_FRAC, SUAD_MODE_BIT_REVERSE, 32'h3000, 16'h0000, 32'h3000, 32'h1122,
         SUAD_SIZE_HALF, 1, 0, 0);
      st(SUAD_OP_LOW_BYTE, SUAD_MODE_DIRECT_ADDR, 32'h0001_2345, 16'h03ff, 32'h0001_2345,
         32'h44, SUAD_SIZE_BYTE, 1, 0, 0);
   endtask : t_long
   task automatic t_compact();
      slow <= 1'b1;
      st(SUAD_OP_DATA_WORD, SUAD_MODE_SHORT_IND, 32'h4000, 16'h000f, 32'h4000, LO,
         SUAD_SIZE_WORD, 1, 0, 0);
      st(SUAD_OP_LOW_BYTE, SUAD_MODE_SHORT_IMPL_B, 32'h9999_0000, 16'h03fc, 32'h500c, 32'h44,
         SUAD_SIZE_BYTE, 1, 0, 0);
      st(SUAD_OP_LOW_HALF, SUAD_MODE_SHORT_IMPL_R, 32'h6000, 16'hfffa, 32'h600a, 32'h3344,
         SUAD_SIZE_HALF, 1, 0, 0);
      slow <= 1'b0;
      st(SUAD_OP_POINTER_WORD, SUAD_MODE_SHORT_POST, 32'hffff_fffe, 16'h0000, 32'hffff_fffe,
         LO, SUAD_SIZE_WORD, 1, 1, 32'h2);
      st(SUAD_OP_DATA_WORD, SUAD_MODE_SHORT_POST, 32'h4100, 16'h0005, 32'h4100, LO,
         SUAD_SIZE_WORD, 1, 1, 32'h4104);
      st(SUAD_OP_LOW_BYTE, SUAD_MODE_SHORT_POST, 32'h4200, 16'h0000, 32'h4200, 32'h44,
         SUAD_SIZE_BYTE, 1, 1, 32'h4201);
      st(SUAD_OP_LOW_HALF, SUAD_MODE_SHORT_POST, 32'h4300, 16'h0000, 32'h4300, 32'h3344,
         SUAD_SIZE_HALF, 1, 1, 32'h4301);
   endtask : t_compact
   task automatic t_pairs();
      slow <= 1'b1;
      st(SUAD_OP_DATA_PAIR, SUAD_MODE_CIRCULAR, 32'h7002, 16'h0000, 32'h7002, LO,
         SUAD_SIZE_WORD, 2, 0, 0);
      chk(mem.wa[1], 32'h7006);
      chk(mem.wd[1], HI);
      slow <= 1'b0;
      st(SUAD_OP_POINTER_PAIR, SUAD_MODE_PRE_INC, 32'h8000, 16'h0008, 32'h8008, LO,
         SUAD_SIZE_WORD, 2, 1, 32'h8008);
      chk(mem.wa[1], 32'h800c);
      chk(mem.wd[1], HI);
   endtask : t_pairs
   task automatic t_illegal();
      st(SUAD_OP_UPPER_FRAC, SUAD_MODE_SHORT_IND, 32'h10, 16'h0, 32'h0, 32'h0,
         SUAD_SIZE_HALF, 0, 0, 0);
      st(SUAD_OP_LOW_BYTE, SUAD_MODE_BASE_WIDE, 32'h10, 16'h0, 32'h0, 32'h0,
         SUAD_SIZE_BYTE, 0, 0, 0);
      st(SUAD_OP_SINGLE_BIT, SUAD_MODE_BASE_DISP, 32'h10, 16'h0, 32'h0, 32'h0,
         SUAD_SIZE_BYTE, 0, 0, 0);
      st(SUAD_OP_DATA_WORD, SUAD_MODE_DIRECT_BIT, 32'h10, 16'h0, 32'h0, 32'h0,
         SUAD_SIZE_WORD, 0, 0, 0);
   endtask : t_illegal
   // Every bit position, alternating value, memory speed switching every two positions
   task automatic t_bit();
      logic [7:0] e;
      for (int p = 0; p < 8; p++) begin
         // Blocking: st copies these into the request at once
         bpos = p[2:0];
         bval = p[0];
         slow <= p[1];
         rd_byte <= p[0] ? 8'h00 : 8'hff;
         e = p[0] ? (8'h01 << p) : ~(8'h01 << p);
         st(SUAD_OP_SINGLE_BIT, SUAD_MODE_DIRECT_BIT, 32'h0003_fffd, 16'h0000, 32'h0003_fffd,
            {24'h0, e}, SUAD_SIZE_BYTE, 1, 0, 0);
      end
   endtask : t_bit
   ////////////////////////////////////////
   initial begin
      repeat (5) @(posedge mclk_in);
      sys_rst_in <= 1'b0;
      #1;
      chk({29'h0, ready, mreq, done}, 32'h4);
      t_long();
      t_compact();
      t_pairs();
      t_illegal();
      t_bit();
      finish_test();
   end
   // Far beyond the roughly 150 cycles the scenarios need
   initial begin
      #200000;
      failures++;
      finish_test();
   end
endmodule : suad_store_unit_tb
`default_nettype wire
